// ===== rtl/seq_pkg.sv
// Constants and types shared by the instruction sequencer
package seq_pkg;
  // ==========================================
  // Sequencing phases, one-hot
  typedef enum logic [3:0] {
    fetch_phase = 4'h1,
    decode_phase = 4'h2,
    execute_phase = 4'h4,
    commit_phase = 4'h8
  } phase_type;

  // ==========================================
  // Register map, byte addresses
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFS_PC_LOW = 5'h00;
  localparam logic [4:0] OFS_CONTROL = 5'h04;
  localparam logic [4:0] OFS_STATUS = 5'h08;
  localparam logic [4:0] OFS_ALU = 5'h0C;
  // Control fields: run, code bank select, interrupt enable
  localparam int CTL_RUN = 0;
  localparam int CTL_BANK = 1;
  localparam int CTL_IEN = 2;
  localparam logic [2:0] CTL_RESET = 3'h1;
  // Status fields above the 4-bit stack depth
  localparam int ST_FULL = 4;
  localparam int ST_OVF = 5;
  // Arithmetic register fields above the accumulator
  localparam int ALU_CARRY = 8;
  localparam int ALU_ZERO = 9;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // ==========================================
  // Instruction word
  localparam int INSTR_W = 16;
  localparam int OPC_MSB = 15;
  localparam int OPC_LSB = 13;
  localparam int AOP_MSB = 12;
  localparam int AOP_LSB = 10;
  localparam int DEST_BIT = 9;
  localparam int REG_COUNT = 4;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] IRQ_VECTOR = 16'h0004;

  typedef enum logic [2:0] {
    op_alu = 3'h0,
    jump_instr = 3'h1,
    op_call = 3'h2,
    subroutine_return_instr = 3'h3,
    interrupt_return_instr = 3'h4,
    op_skip_zero = 3'h5,
    op_table_read = 3'h6,
    op_pcl_write = 3'h7
  } opcode_type;

  typedef enum logic [2:0] {
    alu_add = 3'h0,
    alu_sub = 3'h1,
    alu_and = 3'h2,
    alu_or = 3'h3,
    alu_xor = 3'h4,
    alu_inc = 3'h5,
    alu_dec = 3'h6,
    alu_mov = 3'h7
  } alu_op_type;
endpackage

// ===== rtl/cpu_fetch_sequencer_stack.sv
// Instruction sequencer: phases, program counter, flush, return stack

// ==========================================
module cpu_fetch_sequencer_stack #(
  parameter int PC_WIDTH = 13,
  parameter bit HAS_BANK = 1'h1,
  parameter int STACK_DEPTH = 8
) (
  input logic clk,
  input logic rst_n,
  input logic [seq_pkg::ADDR_W-1:0] address,
  input logic read,
  input logic write,
  input logic [31:0] writedata,
  input logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [PC_WIDTH:0] fetch_addr,
  output logic fetch_en,
  input logic [seq_pkg::INSTR_W-1:0] instr_data,
  input logic irq_req,
  output logic irq_ack
);
  localparam int AW = PC_WIDTH + 1;
  localparam int SPW = $clog2(STACK_DEPTH);
  localparam int CW = $clog2(STACK_DEPTH + 1);
  localparam int RW = $clog2(seq_pkg::REG_COUNT);

  // ==========================================
  // Reset release
  logic rst_meta;
  logic rst_q;

  // Assert at once, release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'h0;
      rst_q <= 1'h0;
    end else begin
      rst_meta <= 1'h1;
      rst_q <= rst_meta;
    end
  end

  // ==========================================
  // State
  seq_pkg::phase_type phase;
  seq_pkg::phase_type next_phase;
  logic [PC_WIDTH-1:0] pc;
  logic [PC_WIDTH-1:0] next_pc;
  logic bank;
  logic next_bank;
  logic [seq_pkg::INSTR_W-1:0] prefetch;
  logic [seq_pkg::INSTR_W-1:0] exec_word;
  logic exec_valid;
  logic [2:0] ctl;
  logic pcl_pend;
  logic [7:0] pcl_val;
  logic [7:0] acc;
  logic carry;
  logic zero;
  logic [7:0] regs [seq_pkg::REG_COUNT];
  logic [AW-1:0] stack_mem [STACK_DEPTH];
  logic [SPW-1:0] wp;
  logic [CW-1:0] depth;
  logic ovf;
  logic [8:0] alu_res;
  logic [31:0] rd_mux;

  // ==========================================
  // Decode of the executing instruction
  wire run = ctl[seq_pkg::CTL_RUN];
  wire boundary = run && (phase == seq_pkg::commit_phase);
  wire [2:0] opc = exec_word[seq_pkg::OPC_MSB:seq_pkg::OPC_LSB];
  wire [2:0] aop = exec_word[seq_pkg::AOP_MSB:seq_pkg::AOP_LSB];
  wire [RW-1:0] ridx = exec_word[RW-1:0];
  wire [7:0] opnd = regs[ridx];
  wire [PC_WIDTH-1:0] target = exec_word[PC_WIDTH-1:0];
  wire is_alu = exec_valid && (opc == seq_pkg::op_alu);
  wire is_jump = exec_valid && (opc == seq_pkg::jump_instr);
  wire is_call = exec_valid && (opc == seq_pkg::op_call);
  wire is_interrupt_return_instr = exec_valid && (opc == seq_pkg::interrupt_return_instr);
  wire is_ret = is_interrupt_return_instr ||
    (exec_valid && (opc == seq_pkg::subroutine_return_instr));
  wire is_skip = exec_valid && (opc == seq_pkg::op_skip_zero);
  wire is_tab = exec_valid && (opc == seq_pkg::op_table_read);
  wire is_pclw = exec_valid && (opc == seq_pkg::op_pcl_write);
  wire skip_taken = is_skip && (opnd == seq_pkg::BYTE_RESET);
  wire ctl_xfer = is_jump || is_call || is_ret || skip_taken || is_pclw;
  wire full = depth == CW'(STACK_DEPTH);
  // Bus low-byte write waits for a cycle free of other transfers
  wire pcl_take = pcl_pend && !ctl_xfer && !is_tab;
  wire irq_take = irq_req && ctl[seq_pkg::CTL_IEN] && !full &&
    !ctl_xfer && !is_tab && !pcl_pend;
  wire redirect = ctl_xfer || pcl_take || irq_take;
  wire push = boundary && (is_call || irq_take);
  wire pop = boundary && is_ret;
  wire [AW-1:0] stack_top = stack_mem[wp - 1'h1];
  wire [PC_WIDTH-9:0] pc_page = pc[PC_WIDTH-1:8];
  wire arith = (aop == seq_pkg::alu_add) || (aop == seq_pkg::alu_sub);
  // Carry reads as no-borrow after a subtract
  wire next_carry = (aop == seq_pkg::alu_sub) ? !alu_res[8] : alu_res[8];
  // Bus decode, ahead of every process that reads it
  wire [4:0] word_addr = {address[4:2], 2'h0};
  wire hit_pcl = word_addr == seq_pkg::OFS_PC_LOW;
  wire hit_ctl = word_addr == seq_pkg::OFS_CONTROL;
  wire hit_st = word_addr == seq_pkg::OFS_STATUS;
  wire hit_alu = word_addr == seq_pkg::OFS_ALU;
  wire bus_req = (read || write) && waitrequest;
  wire wr_go = write && !waitrequest;
  wire wr_lo = wr_go && byteenable[0];
  wire wr_hi = wr_go && byteenable[1];

  // ==========================================
  // Phase ring
  // four phases per cycle
  always_comb begin
    next_phase = phase;
    if (run) begin
      unique case (phase)
        seq_pkg::fetch_phase: next_phase = seq_pkg::decode_phase;
        seq_pkg::decode_phase: next_phase = seq_pkg::execute_phase;
        seq_pkg::execute_phase: next_phase = seq_pkg::commit_phase;
        seq_pkg::commit_phase: next_phase = seq_pkg::fetch_phase;
        default: next_phase = seq_pkg::fetch_phase;
      endcase
    end
  end

  // ==========================================
  // Next program counter, priority top down
  always_comb begin
    next_pc = pc + 1'h1;
    next_bank = bank;
    if (is_jump || is_call) begin
      next_pc = target;
      next_bank = HAS_BANK & ctl[seq_pkg::CTL_BANK];
    end else if (is_ret) begin
      {next_bank, next_pc} = stack_top;
    end else if (is_pclw) begin
      next_pc = {pc_page, acc};
    end else if (irq_take) begin
      next_pc = PC_WIDTH'(seq_pkg::IRQ_VECTOR);
      next_bank = 1'h0;
    end else if (pcl_take) begin
      next_pc = {pc_page, pcl_val};
    end else if (is_tab) begin
      next_pc = pc;
    end
  end

  // ==========================================
  // Pipeline: fetch in one cycle, execute in the next
  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      phase <= seq_pkg::fetch_phase;
      pc <= PC_WIDTH'(seq_pkg::RESET_VECTOR);
      bank <= 1'h0;
      prefetch <= 16'h0000;
      exec_word <= 16'h0000;
      exec_valid <= 1'h0;
      irq_ack <= 1'h0;
    end else begin
      phase <= next_phase;
      irq_ack <= boundary && irq_take;
      if (run && (phase == seq_pkg::fetch_phase)) begin
        prefetch <= instr_data;
      end
      if (boundary) begin
        pc <= next_pc;
        bank <= next_bank;
        exec_word <= prefetch;
        exec_valid <= !(redirect || is_tab);
      end
    end
  end

  assign fetch_addr = {bank, pc};
  assign fetch_en = phase[0];

  // ==========================================
  // Arithmetic unit
  // eight-bit operations
  always_comb begin
    unique case (aop)
      seq_pkg::alu_add: alu_res = {1'h0, acc} + {1'h0, opnd};
      seq_pkg::alu_sub: alu_res = {1'h0, acc} - {1'h0, opnd};
      seq_pkg::alu_and: alu_res = {1'h0, acc & opnd};
      seq_pkg::alu_or: alu_res = {1'h0, acc | opnd};
      seq_pkg::alu_xor: alu_res = {1'h0, acc ^ opnd};
      seq_pkg::alu_inc: alu_res = {1'h0, opnd} + 9'h001;
      seq_pkg::alu_dec: alu_res = {1'h0, opnd} - 9'h001;
      default: alu_res = {1'h0, opnd};
    endcase
  end

  // Results land at the end of the commit phase; the unit wins
  // over a bus write to the accumulator in the same cycle
  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      acc <= seq_pkg::BYTE_RESET;
      carry <= 1'h0;
      zero <= 1'h0;
    end else begin
      if (wr_lo && hit_alu) begin
        acc <= writedata[7:0];
      end
      if (wr_hi && hit_alu) begin
        carry <= writedata[seq_pkg::ALU_CARRY];
        zero <= writedata[seq_pkg::ALU_ZERO];
      end
      if (boundary && is_alu) begin
        if (!exec_word[seq_pkg::DEST_BIT]) begin
          acc <= alu_res[7:0];
        end
        zero <= alu_res[7:0] == seq_pkg::BYTE_RESET;
        if (arith) begin
          carry <= next_carry;
        end
      end
    end
  end

  // Data registers named by the instruction
  for (genvar i = 0; i < seq_pkg::REG_COUNT; i++) begin : g_reg
    always_ff @(posedge clk or negedge rst_q) begin
      if (!rst_q) begin
        regs[i] <= seq_pkg::BYTE_RESET;
      end else if (boundary && is_alu && exec_word[seq_pkg::DEST_BIT] &&
                   (ridx == RW'(i))) begin
        regs[i] <= alu_res[7:0];
      end
    end
  end

  // ==========================================
  // Return stack, never mapped onto the bus
  // push saves bank and counter
  always_ff @(posedge clk) begin
    if (push) begin
      stack_mem[wp] <= {bank, pc};
    end
  end

  // Circular write pointer: a push when full overwrites the oldest
  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      wp <= {SPW{1'h0}};
      depth <= {CW{1'h0}};
    end else if (push) begin
      wp <= wp + 1'h1;
      if (!full) begin
        depth <= depth + 1'h1;
      end
    end else if (pop && (depth != {CW{1'h0}})) begin
      wp <= wp - 1'h1;
      depth <= depth - 1'h1;
    end
  end

  // ==========================================
  // Avalon-MM slave, one wait cycle per access

  // low byte readable; unmapped reads zero
  assign rd_mux = hit_pcl ? {24'h000000, pc[7:0]} :
                  hit_ctl ? {29'h00000000, ctl} :
                  hit_st ? {26'h0000000, ovf, full, 4'(depth)} :
                  hit_alu ? {22'h000000, zero, carry, acc} :
                  32'h00000000;

  // Read data is captured while waitrequest drops
  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      waitrequest <= 1'h1;
      readdata <= 32'h00000000;
    end else begin
      waitrequest <= !bus_req;
      if (bus_req && read) begin
        readdata <= rd_mux;
      end
    end
  end

  // Control and flags; hardware events are written last so they win, except the pending low-byte flag, where the bus write wins
  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      ctl <= seq_pkg::CTL_RESET;
      pcl_pend <= 1'h0;
      pcl_val <= seq_pkg::BYTE_RESET;
      ovf <= 1'h0;
    end else begin
      if (wr_lo && hit_ctl) begin
        ctl <= writedata[2:0];
      end
      if (boundary && irq_take) begin
        ctl[seq_pkg::CTL_IEN] <= 1'h0;
      end
      if (boundary && is_interrupt_return_instr) begin
        ctl[seq_pkg::CTL_IEN] <= 1'h1;
      end
      if (boundary && pcl_take) begin
        pcl_pend <= 1'h0;
      end
      if (wr_lo && hit_pcl) begin
        pcl_pend <= 1'h1;
        pcl_val <= writedata[7:0];
      end
      if (wr_lo && hit_st && writedata[seq_pkg::ST_OVF]) begin
        ovf <= 1'h0;
      end
      if (push && full) begin
        ovf <= 1'h1;
      end
    end
  end

  // ==========================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_q);

  phase_ring_a: assert property (
    (phase == seq_pkg::fetch_phase && run) ##1 run [*3]
    |=> phase == seq_pkg::fetch_phase)
    else $error("phase ring broken");

  // counter only moves at fetch start
  pc_hold_a: assert property (
    !boundary |=> $stable(pc))
    else $error("counter moved mid cycle");

  pc_step_a: assert property (
    boundary && !redirect && !is_tab
    |=> (pc == $past(pc) + 1'h1) && exec_valid)
    else $error("counter step wrong");

  jump_flush_a: assert property (
    boundary && (is_jump || is_call)
    |=> !exec_valid && (pc == $past(target)))
    else $error("branch not flushed or loaded");

  skip_dummy_a: assert property (
    boundary && skip_taken
    |=> !exec_valid && (pc == $past(pc) + 1'h1))
    else $error("skip not discarded");

  call_push_a: assert property (
    boundary && is_call && !full
    |=> (depth == $past(depth) + 1'h1) &&
        (stack_top == $past(fetch_addr)))
    else $error("call did not push");

  ret_pop_a: assert property (
    boundary && is_ret && (depth != {CW{1'h0}})
    |=> ({bank, pc} == $past(stack_top)) &&
        (depth == $past(depth) - 1'h1))
    else $error("return did not restore");

  irq_block_a: assert property (
    boundary && full |=> !irq_ack)
    else $error("interrupt taken on full stack");

  irq_vector_a: assert property (
    irq_ack |-> (pc == PC_WIDTH'(seq_pkg::IRQ_VECTOR)) && !exec_valid)
    else $error("interrupt vector wrong");

  pcl_page_a: assert property (
    boundary && pcl_take
    |=> (pc_page == $past(pc_page)) && (pc[7:0] == $past(pcl_val)) &&
        !exec_valid)
    else $error("low byte jump wrong");

  stack_ovf_a: assert property (
    boundary && is_call && full |=> full && ovf)
    else $error("overflow not flagged");

  table_two_a: assert property (
    boundary && is_tab |=> !exec_valid && $stable(pc))
    else $error("table read not two cycles");

  reset_state_a: assert property (
    $rose(rst_q) |-> (pc == PC_WIDTH'(seq_pkg::RESET_VECTOR)) &&
                     (depth == {CW{1'h0}}))
    else $error("reset state wrong");

  call_seen_c: cover property (boundary && is_call);
  irq_seen_c: cover property (irq_ack);
  ret_seen_c: cover property (boundary && is_interrupt_return_instr);
  overflow_c: cover property (push && full);
endmodule // cpu_fetch_sequencer_stack

// ===== verif/prog_mem_model.sv
// Program memory and interrupt source that face the sequencer
module prog_mem_model #(
  parameter int AW = 14
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [AW-1:0] fetch_addr,
  output logic [15:0] instr_data,
  input wire logic irq_raise,
  input wire logic irq_ack,
  output logic irq_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Code store
  logic [15:0] rom [0:(1<<AW)-1];
  // Word answers within the fetch-phase cycle
  assign instr_data = rom[fetch_addr];

  // ==========================================
  // Request flag
  // flag stays recorded
  // Held until acknowledged, so a full stack only delays service;
  // dropping on the ack avoids a second entry once enable returns
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_req <= 1'h0;
    end else if (irq_ack) begin
      irq_req <= 1'h0;
    end else if (irq_raise) begin
      irq_req <= 1'h1;
    end
  end
endmodule // prog_mem_model

// ===== verif/cpu_fetch_sequencer_stack_tb_top.sv
// Self-checking bench for the instruction sequencer
module cpu_fetch_sequencer_stack_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, read, write, waitrequest, fetch_en;
  logic irq_req, irq_ack, irq_raise, fe_q;
  logic [4:0] address;
  logic [31:0] writedata, readdata, rd;
  logic [3:0] byteenable;
  logic [13:0] fetch_addr;
  logic [15:0] instr_data;
  logic [13:0] trace [$];
  logic [13:0] want [$];
  int err_total, checked, acks;

  cpu_fetch_sequencer_stack u_dut (.clk(clk), .rst_n(rst_n),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .fetch_addr(fetch_addr), .fetch_en(fetch_en),
    .instr_data(instr_data), .irq_req(irq_req), .irq_ack(irq_ack));

  prog_mem_model u_mem (.clk(clk), .rst_n(rst_n),
    .fetch_addr(fetch_addr), .instr_data(instr_data),
    .irq_raise(irq_raise), .irq_ack(irq_ack), .irq_req(irq_req));

  // 40 MHz system clock
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  // Record each fetch address once, at the start of its fetch phase
  always @(posedge clk) begin
    fe_q <= fetch_en && rst_n;
    if (rst_n && fetch_en && !fe_q) trace.push_back(fetch_addr);
    if (irq_ack === 1'h1) acks++;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until the edge that sees waitrequest low
  task automatic bus_write(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= 1'h1;
    do @(posedge clk); while (waitrequest !== 1'h0);
    write <= 1'h0;
  endtask

  task automatic bus_read(input logic [4:0] a);
    @(posedge clk);
    address <= a;
    read <= 1'h1;
    do @(posedge clk); while (waitrequest !== 1'h0);
    rd = readdata;
    read <= 1'h0;
  endtask

  task automatic wait_addr(input logic [13:0] a, input int lim);
    int i;
    i = 0;
    while (fetch_addr !== a && i < lim) begin
      @(negedge clk);
      i++;
    end
    // One more cycle so the trace has logged the address
    @(negedge clk);
    check(32'(fetch_addr), 32'(a));
  endtask

  // Expected addresses must appear in this order after a mark
  task automatic seq_check(input int from);
    int j;
    j = 0;
    for (int i = from; i < trace.size(); i++)
      if (j < want.size() && trace[i] === want[j]) j++;
    check(32'(j), 32'(want.size()));
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Whole sequence needs about 400 cycles; fifty times that is a hang
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    conclude();
  end

  // ==========================================
  // Main sequence
  initial begin
    int i;
    int mark;
    int cnt;
    rst_n = 1'h0;
    read = 1'h0;
    write = 1'h0;
    address = 5'h00;
    writedata = 32'h0;
    byteenable = 4'hF;
    irq_raise = 1'h0;
    // Default word ORs register 0 into the accumulator: no transfer
    for (int a = 0; a < 16384; a++) u_mem.rom[a] = 16'h0C00;
    u_mem.rom[14'h000] = 16'h4010;
    u_mem.rom[14'h001] = 16'h2020;
    u_mem.rom[14'h004] = 16'h8000;
    u_mem.rom[14'h010] = 16'h6000;
    u_mem.rom[14'h020] = 16'hA000;
    u_mem.rom[14'h021] = 16'h2030;
    u_mem.rom[14'h022] = 16'h2140;
    // Nine nested calls; return words sit at the return addresses
    for (int k = 0; k < 9; k++)
      u_mem.rom[14'h180 + 2*k] = 16'h4182 + 16'(2*k);
    for (int k = 0; k < 7; k++) u_mem.rom[14'h185 + 2*k] = 16'h6000;
    u_mem.rom[14'h183] = 16'h21C0;
    u_mem.rom[14'h193] = 16'h2192;
    u_mem.rom[14'h1A0] = 16'h6000;
    u_mem.rom[14'h1C1] = 16'h21C0;
    u_mem.rom[14'h21C1] = 16'h21C0;
    // Increment reg1, add it in, table read, accumulator page jump
    u_mem.rom[14'h21E0] = 16'h1601;
    u_mem.rom[14'h21E1] = 16'h0001;
    u_mem.rom[14'h21E2] = 16'hC000;
    u_mem.rom[14'h21E3] = 16'hE000;
    u_mem.rom[14'h21A6] = 16'h21A6;
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge clk);
    // Reset values, unmapped place reads zero
    bus_read(seq_pkg::OFS_CONTROL);
    check(rd, 32'h1);
    bus_read(seq_pkg::OFS_STATUS);
    check(rd, 32'h0);
    bus_read(5'h10);
    check(rd, 32'h0);
    // Freeze the ring so the accumulator write cannot collide
    bus_write(seq_pkg::OFS_CONTROL, 32'h0);
    bus_write(seq_pkg::OFS_ALU, 32'h1A5);
    bus_write(5'h10, 32'hFF);
    bus_read(seq_pkg::OFS_ALU);
    check(rd, 32'h1A5);
    bus_read(5'h10);
    check(rd, 32'h0);
    bus_write(seq_pkg::OFS_CONTROL, 32'h1);
    // Call, return, jump and taken skip through to page one
    wait_addr(14'h140, 600);
    want = {14'h0, 14'h1, 14'h10, 14'h11, 14'h1, 14'h2, 14'h20, 14'h21,
            14'h22, 14'h23, 14'h140};
    for (int k = 0; k < 11; k++)
      check(32'(trace[k]), 32'(want[k]));
    bus_read(seq_pkg::OFS_PC_LOW);
    check(32'(rd[31:6] == 26'h1), 32'h1);
    // Low byte write jumps inside the current page
    bus_write(seq_pkg::OFS_PC_LOW, 32'h80);
    wait_addr(14'h180, 40);
    // Nine calls on eight levels
    wait_addr(14'h193, 400);
    bus_read(seq_pkg::OFS_STATUS);
    check(rd, 32'h38);
    bus_write(seq_pkg::OFS_STATUS, 32'h20);
    bus_read(seq_pkg::OFS_STATUS);
    check(rd, 32'h18);
    // Interrupt held off while full
    bus_write(seq_pkg::OFS_CONTROL, 32'h5);
    @(posedge clk);
    irq_raise <= 1'h1;
    @(posedge clk);
    irq_raise <= 1'h0;
    repeat (60) @(posedge clk);
    check(32'(acks), 32'h0);
    mark = trace.size();
    bus_write(seq_pkg::OFS_PC_LOW, 32'hA0);
    i = 0;
    while (acks == 0 && i < 800) begin
      @(negedge clk);
      i++;
    end
    check(32'(acks), 32'h1);
    wait_addr(14'h1C0, 800);
    want = {14'h1A0, 14'h191, 14'h18F, 14'h18D, 14'h18B, 14'h189,
            14'h187, 14'h185, 14'h183, 14'h1C0};
    seq_check(mark);
    want = {14'h004};
    seq_check(mark);
    bus_read(seq_pkg::OFS_STATUS);
    check(rd, 32'h0);
    bus_read(seq_pkg::OFS_CONTROL);
    check(rd, 32'h5);
    // Bank bit becomes the top address bit on the next jump
    bus_write(seq_pkg::OFS_CONTROL, 32'h3);
    wait_addr(14'h21C0, 100);
    // One fetch phase in every four clocks
    cnt = 0;
    repeat (40) begin
      @(negedge clk);
      cnt += int'(fetch_en === 1'h1);
    end
    check(32'(cnt), 32'hA);
    // Table read refetches once; low byte comes from the accumulator
    mark = trace.size();
    bus_write(seq_pkg::OFS_PC_LOW, 32'hE0);
    wait_addr(14'h21A6, 100);
    want = {14'h21E2, 14'h21E3, 14'h21E3, 14'h21E4, 14'h21A6};
    seq_check(mark);
    bus_read(seq_pkg::OFS_ALU);
    check(rd, 32'hA6);
    conclude();
  end
endmodule // cpu_fetch_sequencer_stack_tb_top
